// file: design/fm_pkg.sv
/*
  Package of the fault manager: register offsets, field positions, reset values and source codes.
  Assumes a 16-bit register port whose addresses are the printed word offsets.
*/
package fm_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] FM_ADDR_CLEAR = 16'hF421;
  localparam logic [15:0] FM_ADDR_PARITY_MASK = 16'hF422;
  localparam logic [15:0] FM_ADDR_SOFT_MASK = 16'hF423;
  localparam logic [15:0] FM_ADDR_WDOG_MASK = 16'hF424;
  localparam logic [15:0] FM_ADDR_STACK_MASK = 16'hF425;
  localparam logic [15:0] FM_ADDR_LOOP_MASK = 16'hF426;
  localparam logic [15:0] FM_ADDR_FLAG = 16'hF427;
  localparam logic [15:0] FM_ADDR_CODE = 16'hF428;
  localparam logic [15:0] FM_ADDR_IRQ_STATUS = 16'hF429;
  localparam logic [15:0] FM_ADDR_IRQ_CLEAR = 16'hF42A;
  localparam logic [15:0] FM_ADDR_IRQ_ENABLE = 16'hF42B;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] FM_PARITY_MASK_RESET = 12'h003;
  localparam logic FM_BIT_MASK_RESET = 1'b0;
  localparam logic [15:0] FM_CODE_RESET = 16'h0000;
  localparam logic [1:0] FM_IRQ_RESET = 2'h0;

  // ---------------------------------------------------------------
  // Source positions in the fault code
  // ---------------------------------------------------------------
  localparam int FM_POS_SOFT = 15;
  localparam int FM_POS_LOOP = 14;
  localparam int FM_POS_STACK = 13;
  localparam int FM_POS_WDOG = 12;
  localparam int FM_PARITY_W = 12;
  localparam int FM_SRC_W = 16;

  // ---------------------------------------------------------------
  // Interrupt status fields
  // ---------------------------------------------------------------
  localparam int FM_IRQ_ACCEPT = 0;
  localparam int FM_IRQ_FIRST = 1;
  localparam int FM_IRQ_W = 2;

endpackage : fm_pkg

// file: design/fm_capture_if.sv
/*
  Interface between the register side and the fault capture core.
  Assumes both ends run on the one core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface fm_capture_if;
  import fm_pkg::*;
  logic [FM_SRC_W-1:0] fault_src;
  logic [FM_SRC_W-1:0] fault_mask;
  logic clear_pulse;
  logic accept_any;
  logic first_capture;
  logic flag;
  logic [FM_SRC_W-1:0] code;

  modport core (
    input fault_src, fault_mask, clear_pulse,
    output accept_any, first_capture, flag, code
  );
  modport regs (
    output fault_src, fault_mask, clear_pulse,
    input accept_any, first_capture, flag, code
  );
endinterface : fm_capture_if
`default_nettype wire

// file: design/fm_capture.sv
/*
  Fault capture core: masks each source, keeps the sticky flag and the first-fault code.
  Assumes sources are one bit per position of the code, synchronous to the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fm_capture
  import fm_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register side
  fm_capture_if.core cap
);

  // ---------------------------------------------------------------
  // Masking
  // ---------------------------------------------------------------
  logic [FM_SRC_W-1:0] accepted;
  logic flag;
  logic [FM_SRC_W-1:0] code;
  logic code_empty;
  logic [FM_SRC_W-1:0] next_code;
  logic next_flag;

  // A masked source never reaches the flag or code, so it cannot claim first place
  assign accepted = cap.fault_src & ~cap.fault_mask;
  assign code_empty = (code == FM_CODE_RESET) || cap.clear_pulse;
  // All sources of the first cycle land together
  assign next_code = code_empty ? accepted : code;
  // New error in the clear cycle wins over the clear
  assign next_flag = (flag && !cap.clear_pulse) || (|accepted);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag <= 1'b0;
      code <= FM_CODE_RESET;
    end else begin
      flag <= next_flag;
      code <= next_code;
    end
  end

  assign cap.flag = flag;
  assign cap.code = code;
  assign cap.accept_any = |accepted;
  assign cap.first_capture = code_empty && (|accepted);

endmodule : fm_capture
`default_nettype wire

// file: design/fm_top.sv
/*
  Fault manager top: register port, source masks, clear edge detection and interrupt.
  Assumes error sources come from logic on the core clock and the register master
  issues one-cycle strobes; read data stands in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module fm_top
  import fm_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [15:0] rd_data_out,
  // Error sources
  input wire logic [FM_PARITY_W-1:0] parity_err_in,
  input wire logic soft_fault_in,
  input wire logic loop_fault_in,
  input wire logic stack_fault_in,
  input wire logic watchdog_fault_in,
  // Status
  output logic fault_flag_out,
  output logic [FM_SRC_W-1:0] fault_code_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [FM_PARITY_W-1:0] parity_report_mask;
  logic software_fault_mask;
  logic watchdog_fault_mask;
  logic stack_fault_mask;
  logic loop_fault_mask;
  logic clear_bit;
  logic [FM_IRQ_W-1:0] irq_status;
  logic [FM_IRQ_W-1:0] irq_enable;

  fm_capture_if cap ();

  fm_capture u_capture (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cap(cap)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire hit_clear = addr_in == FM_ADDR_CLEAR;
  wire hit_parity = addr_in == FM_ADDR_PARITY_MASK;
  wire hit_soft = addr_in == FM_ADDR_SOFT_MASK;
  wire hit_wdog = addr_in == FM_ADDR_WDOG_MASK;
  wire hit_stack = addr_in == FM_ADDR_STACK_MASK;
  wire hit_loop = addr_in == FM_ADDR_LOOP_MASK;
  wire hit_flag = addr_in == FM_ADDR_FLAG;
  wire hit_code = addr_in == FM_ADDR_CODE;
  wire hit_irq_status = addr_in == FM_ADDR_IRQ_STATUS;
  wire hit_irq_clear = addr_in == FM_ADDR_IRQ_CLEAR;
  wire hit_irq_enable = addr_in == FM_ADDR_IRQ_ENABLE;

  wire wr_clear = wr_en_in && hit_clear;
  wire wr_irq_clear = wr_en_in && hit_irq_clear;
  // Only a 0 to 1 change of the stored bit clears; rewriting 1 does nothing
  wire clear_rise = wr_clear && wr_data_in[0] && !clear_bit;

  // ---------------------------------------------------------------
  // Source and mask assembly
  // ---------------------------------------------------------------
  // Parity sources sit in the code at their mask positions
  assign cap.fault_src = {soft_fault_in, loop_fault_in, stack_fault_in,
                          watchdog_fault_in, parity_err_in};
  assign cap.fault_mask = {software_fault_mask, loop_fault_mask, stack_fault_mask,
                           watchdog_fault_mask, parity_report_mask};
  assign cap.clear_pulse = clear_rise;

  // ---------------------------------------------------------------
  // Mask and clear registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      parity_report_mask <= FM_PARITY_MASK_RESET;
      software_fault_mask <= FM_BIT_MASK_RESET;
      watchdog_fault_mask <= FM_BIT_MASK_RESET;
      stack_fault_mask <= FM_BIT_MASK_RESET;
      loop_fault_mask <= FM_BIT_MASK_RESET;
      clear_bit <= 1'b0;
    end else if (wr_en_in) begin
      if (hit_parity) begin
        parity_report_mask <= wr_data_in[FM_PARITY_W-1:0];
      end
      if (hit_soft) begin
        software_fault_mask <= wr_data_in[0];
      end
      if (hit_wdog) begin
        watchdog_fault_mask <= wr_data_in[0];
      end
      if (hit_stack) begin
        stack_fault_mask <= wr_data_in[0];
      end
      if (hit_loop) begin
        loop_fault_mask <= wr_data_in[0];
      end
      if (hit_clear) begin
        clear_bit <= wr_data_in[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  wire [FM_IRQ_W-1:0] irq_events = {cap.first_capture, cap.accept_any};
  wire [FM_IRQ_W-1:0] irq_clr = wr_irq_clear ? wr_data_in[FM_IRQ_W-1:0] : FM_IRQ_RESET;
  // Set wins over a clear in the same cycle
  wire [FM_IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_events;
  wire next_irq = |(next_irq_status & irq_enable);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status <= FM_IRQ_RESET;
      irq_enable <= FM_IRQ_RESET;
      irq_out <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_out <= next_irq;
      if (wr_en_in && hit_irq_enable) begin
        irq_enable <= wr_data_in[FM_IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Reserved bits and unmapped addresses read zero; clear register reads back
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_clear) begin
      rd_mux = {15'h0000, clear_bit};
    end else if (hit_parity) begin
      rd_mux = {4'h0, parity_report_mask};
    end else if (hit_soft) begin
      rd_mux = {15'h0000, software_fault_mask};
    end else if (hit_wdog) begin
      rd_mux = {15'h0000, watchdog_fault_mask};
    end else if (hit_stack) begin
      rd_mux = {15'h0000, stack_fault_mask};
    end else if (hit_loop) begin
      rd_mux = {15'h0000, loop_fault_mask};
    end else if (hit_flag) begin
      rd_mux = {15'h0000, cap.flag};
    end else if (hit_code) begin
      rd_mux = cap.code;
    end else if (hit_irq_status) begin
      rd_mux = {14'h0000, irq_status};
    end else if (hit_irq_enable) begin
      rd_mux = {14'h0000, irq_enable};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
      fault_flag_out <= 1'b0;
      fault_code_out <= FM_CODE_RESET;
    end else begin
      rd_data_out <= rd_en_in ? rd_mux : 16'h0000;
      fault_flag_out <= cap.flag;
      fault_code_out <= cap.code;
    end
  end

endmodule : fm_top
`default_nettype wire

// file: verif/fm_top_monitor.sv
/* Port checker of the fault manager top.
   Assumes one core clock and a synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module fm_top_monitor
  import fm_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [15:0] rd_data_out,
  // Sources and status
  input wire logic [FM_PARITY_W-1:0] parity_err_in,
  input wire logic soft_fault_in,
  input wire logic loop_fault_in,
  input wire logic stack_fault_in,
  input wire logic watchdog_fault_in,
  input wire logic fault_flag_out,
  input wire logic [FM_SRC_W-1:0] fault_code_out,
  input wire logic irq_out
);
  // ----
  // Helpers
  // ----
  wire logic [15:0] src = {soft_fault_in, loop_fault_in, stack_fault_in, watchdog_fault_in, parity_err_in};
  // Conservative: any write of 1 may be a clear, the stored bit is hidden
  wire logic clr_wr = wr_en_in && addr_in == FM_ADDR_CLEAR && wr_data_in[0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_flag_stays: assert property ($fell(fault_flag_out) |-> $past(clr_wr, 2))
    else $error("flag dropped without a clear");
  chk_code_holds: assert property ($changed(fault_code_out) && $past(fault_code_out) != 16'h0000 |-> $past(clr_wr, 2))
    else $error("code changed without a clear");
  chk_flag_code: assert property (fault_flag_out == (fault_code_out != 16'h0000))
    else $error("flag and code disagree");
  chk_code_cause: assert property ($changed(fault_code_out) && fault_code_out != 16'h0000
    |-> (fault_code_out & ~$past(src, 2)) == 16'h0000)
    else $error("code bit without its source");
  chk_rd_flag: assert property (rd_en_in && addr_in == FM_ADDR_FLAG |=> rd_data_out == {15'h0000, fault_flag_out})
    else $error("flag read differs");
  chk_rd_code: assert property (rd_en_in && addr_in == FM_ADDR_CODE |=> rd_data_out == fault_code_out)
    else $error("code read differs");
  chk_rd_bitmask: assert property (rd_en_in && addr_in inside {[FM_ADDR_SOFT_MASK:FM_ADDR_LOOP_MASK]}
    |=> rd_data_out[15:1] == 15'h0000)
    else $error("single mask reserved bits set");
  chk_rd_parity: assert property (rd_en_in && addr_in == FM_ADDR_PARITY_MASK |=> rd_data_out[15:12] == 4'h0)
    else $error("parity mask reserved bits set");
endmodule : fm_top_monitor
`default_nettype wire

// file: verif/fm_top_tb.sv
/* Self-checking bench of the fault manager top against a cycle model.
   Assumes the package, design files and monitor are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module fm_top_tb;
  import fm_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000, wr_data_in = 16'h0000;
  logic wr_en_in = 1'b0, rd_en_in = 1'b0;
  logic [11:0] parity_err_in = 12'h000;
  logic soft_fault_in = 1'b0, loop_fault_in = 1'b0, stack_fault_in = 1'b0, watchdog_fault_in = 1'b0;
  wire logic [15:0] rd_data_out, fault_code_out;
  wire logic fault_flag_out, irq_out;
  logic [31:0] seed = 32'ha9d0, pick;
  int failures = 0, comparisons = 0;
  logic [11:0] m_pm;
  logic m_sw, m_wd, m_st, m_lp, m_clr, m_flag, e_flag, e_irq, clr, first;
  logic [15:0] m_code, e_code, e_rd, acc;
  logic [1:0] m_ist, m_ien, nst;

  always #4 clk_in = ~clk_in;

  fm_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .parity_err_in(parity_err_in),
    .soft_fault_in(soft_fault_in), .loop_fault_in(loop_fault_in), .stack_fault_in(stack_fault_in),
    .watchdog_fault_in(watchdog_fault_in), .fault_flag_out(fault_flag_out),
    .fault_code_out(fault_code_out), .irq_out(irq_out));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [15:0] rmap(input logic [15:0] a);
    case (a)
      FM_ADDR_CLEAR: return {15'h0000, m_clr};
      FM_ADDR_PARITY_MASK: return {4'h0, m_pm};
      FM_ADDR_SOFT_MASK: return {15'h0000, m_sw};
      FM_ADDR_WDOG_MASK: return {15'h0000, m_wd};
      FM_ADDR_STACK_MASK: return {15'h0000, m_st};
      FM_ADDR_LOOP_MASK: return {15'h0000, m_lp};
      FM_ADDR_FLAG: return {15'h0000, m_flag};
      FM_ADDR_CODE: return m_code;
      FM_ADDR_IRQ_STATUS: return {14'h0000, m_ist};
      FM_ADDR_IRQ_ENABLE: return {14'h0000, m_ien};
      default: return 16'h0000;
    endcase
  endfunction : rmap

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One bus cycle; sparse random faults ride along with it
  task automatic cyc(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
    logic [31:0] v;
    @(posedge clk_in);
    v = xs();
    wr_en_in <= w;
    rd_en_in <= r;
    addr_in <= a;
    wr_data_in <= d;
    {soft_fault_in, loop_fault_in, stack_fault_in, watchdog_fault_in, parity_err_in} <=
      (v[4:0] == 5'h00) ? v[31:16] >> v[8:5] : 16'h0000;
  endtask : cyc

  task automatic summarize();
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // ----
  // Model
  // ----
  always @(posedge clk_in) begin
    if (rst_in) begin
      m_pm = 12'h003;
      {m_sw, m_wd, m_st, m_lp, m_clr, m_flag} = 6'h00;
      {m_code, e_code, e_rd, m_ist, m_ien, e_flag, e_irq} = '0;
    end else begin
      acc = {soft_fault_in, loop_fault_in, stack_fault_in, watchdog_fault_in, parity_err_in}
        & ~{m_sw, m_lp, m_st, m_wd, m_pm};
      clr = wr_en_in && addr_in == FM_ADDR_CLEAR && wr_data_in[0] && !m_clr;
      first = (|acc) && (clr || m_code == 16'h0000);
      e_flag = m_flag;
      e_code = m_code;
      e_rd = rd_en_in ? rmap(addr_in) : 16'h0000;
      if (clr) begin
        m_flag = |acc;
        m_code = acc;
      end else if (|acc) begin
        m_flag = 1'b1;
        if (m_code == 16'h0000) m_code = acc;
      end
      nst = m_ist & ~((wr_en_in && addr_in == FM_ADDR_IRQ_CLEAR) ? wr_data_in[1:0] : 2'h0) | {first, |acc};
      e_irq = |(nst & m_ien);
      m_ist = nst;
      if (wr_en_in) begin
        case (addr_in)
          FM_ADDR_CLEAR: m_clr = wr_data_in[0];
          FM_ADDR_PARITY_MASK: m_pm = wr_data_in[11:0];
          FM_ADDR_SOFT_MASK: m_sw = wr_data_in[0];
          FM_ADDR_WDOG_MASK: m_wd = wr_data_in[0];
          FM_ADDR_STACK_MASK: m_st = wr_data_in[0];
          FM_ADDR_LOOP_MASK: m_lp = wr_data_in[0];
          FM_ADDR_IRQ_ENABLE: m_ien = wr_data_in[1:0];
          default: ;
        endcase
      end
    end
  end

  always @(negedge clk_in) begin
    if (!rst_in) begin
      check("flag", {15'h0000, fault_flag_out}, {15'h0000, e_flag});
      check("code", fault_code_out, e_code);
      check("irq", {15'h0000, irq_out}, {15'h0000, e_irq});
      check("rd_data", rd_data_out, e_rd);
    end
  end

  // ----
  // Stimulus
  // ----
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 16; i++) cyc(1'b0, 1'b1, {12'hF42, 4'(i)}, 16'h0000);
    cyc(1'b1, 1'b0, FM_ADDR_IRQ_ENABLE, 16'h0003);
    for (int n = 0; n < 4000; n++) begin
      pick = xs();
      if (n == 2000) begin
        rst_in <= 1'b1;
        repeat (3) cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
        rst_in <= 1'b0;
      end
      case (pick[2:0])
        3'h0, 3'h1: cyc(1'b1, 1'b0, {12'hF42, pick[7:4]}, pick[31:16]);
        3'h2, 3'h3: cyc(1'b0, 1'b1, {12'hF42, pick[7:4]}, 16'h0000);
        3'h4: begin
          cyc(1'b1, 1'b0, FM_ADDR_CLEAR, 16'h0001);
          cyc(1'b1, 1'b0, FM_ADDR_CLEAR, 16'h0000);
        end
        3'h5: cyc(1'b1, 1'b0, {12'hF42, pick[7:4]}, 16'h0000);
        default: cyc(1'b0, 1'b0, 16'h0000, 16'h0000);
      endcase
    end
    summarize();
  end
endmodule : fm_top_tb

bind fm_top fm_top_monitor mon_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
  .parity_err_in(parity_err_in), .soft_fault_in(soft_fault_in), .loop_fault_in(loop_fault_in),
  .stack_fault_in(stack_fault_in), .watchdog_fault_in(watchdog_fault_in),
  .fault_flag_out(fault_flag_out), .fault_code_out(fault_code_out), .irq_out(irq_out));
`default_nettype wire
